// ===== io_unit_pkg.sv
// Shared constants and types for the sequencer I/O instruction unit
package io_unit_pkg;
    // Opcodes of the instruction port
    typedef enum logic [3:0] {
        op_nop = 4'h0,
        op_dio_write = 4'h1,
        op_dio_read = 4'h2,
        op_dio_trig_read = 4'h3,
        op_trigger_out = 4'h4,
        op_wait = 4'h5,
        op_dio_trig_wait = 4'h6,
        op_dig_trig_read = 4'h7,
        op_tag_set = 4'h8,
        op_tag_alias = 4'h9,
        op_play_done_wait = 4'ha,
        op_play = 4'hb,
        op_sync = 4'hc
    } opcode_t;

    typedef enum logic [2:0] {
        st_idle = 3'h0,
        st_wait = 3'h1,
        st_dio_wait = 3'h3,
        st_play_wait = 3'h2,
        st_sync = 3'h6,
        st_play_queue = 3'h7
    } state_t;

    localparam int word_w = 32;
    localparam int trig_w = 4;
    localparam int dig_trig_n = 2;

    // AHB-Lite register map (byte addresses)
    localparam logic [7:0] addr_strobe_cfg = 8'h00;
    localparam logic [7:0] addr_status = 8'h04;
    localparam logic [7:0] addr_dio_out = 8'h08;
    localparam logic [7:0] addr_trig_out = 8'h0c;
    localparam logic [7:0] addr_stream_tag = 8'h10;
    localparam logic [7:0] addr_dio_latched = 8'h14;
    localparam logic [7:0] addr_result = 8'h18;

    // Strobe configuration fields
    localparam int strobe_bit_lsb = 0;
    localparam int strobe_bit_w = 5;
    localparam int strobe_edge_lsb = 8;
    localparam int strobe_edge_w = 2;
    localparam logic [1:0] edge_off = 2'h0;
    localparam logic [1:0] edge_rise = 2'h1;
    localparam logic [1:0] edge_fall = 2'h2;
    localparam logic [1:0] edge_both = 2'h3;

    // Port pacing: system clock 25 MHz against 50 MHz port speed
    localparam int clk_hz = 25_000_000;
    localparam int port_hz = 50_000_000;
    localparam int pace_cycles_raw = (clk_hz + port_hz - 1) / port_hz;
    localparam int pace_cycles = (pace_cycles_raw < 1) ? 1 : pace_cycles_raw;
    localparam logic [3:0] pace_reload = 4'(pace_cycles - 1);
endpackage

// ===== io_unit_if.sv
// Handshake between the instruction decoder and the port pacer
`timescale 1ns/100ps
`default_nettype none
interface io_unit_if;
    logic req;
    logic [31:0] data;
    logic ready;
    modport ctrl (output req, output data, input ready);
    modport pacer (input req, input data, output ready);
endinterface
`default_nettype wire

// ===== dio_pacer.sv
// Paces parallel port output updates to the port interface rate
`timescale 1ns/100ps
`default_nettype none
module dio_pacer (
    input wire logic hclk,
    input wire logic hresetn,
    io_unit_if.pacer link,
    output logic [31:0] port_out
);
    logic [3:0] gap;

    assign link.ready = (gap == 4'h0);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_out <= 32'h0000_0000;
            gap <= 4'h0;
        end else if (link.req && link.ready) begin
            port_out <= link.data;
            gap <= io_unit_pkg::pace_reload;
        end else if (gap != 4'h0) begin
            gap <= gap - 4'h1;
        end
    end
endmodule
`default_nettype wire

// ===== seq_io_unit.sv
// Sequencer I/O and timing instruction unit with AHB-Lite registers
`timescale 1ns/100ps
`default_nettype none
module seq_io_unit (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic instr_valid,
    input wire logic [3:0] instr_op,
    input wire logic [31:0] instr_operand,
    output logic instr_ready,
    output logic result_valid,
    output logic [31:0] result_data,
    input wire logic [31:0] dio_in,
    output logic [31:0] dio_out,
    output logic [3:0] trig_out,
    input wire logic [1:0] dig_trig_in,
    output logic [31:0] stream_tag,
    input wire logic play_busy,
    output logic play_start,
    output logic [31:0] play_index,
    output logic sync_req,
    input wire logic sync_ack
);
    io_unit_pkg::state_t state;
    io_unit_if link ();
    logic [31:0] dio_prev;
    logic [31:0] dio_latched;
    logic [31:0] wait_count;
    logic [9:0] strobe_cfg;
    logic strobe_hit;
    logic accept;
    logic [31:0] pend_play;
    logic ahb_wr;
    logic [7:0] ahb_addr;
    logic [31:0] next_rdata;

    function automatic logic pick_bit(input logic [31:0] w,
                                      input logic [4:0] idx);
        pick_bit = w[idx];
    endfunction

    // Strobe detection on the configured port bit and edge
    always_comb begin
        logic now_b;
        logic old_b;
        logic [4:0] sel;
        sel = strobe_cfg[io_unit_pkg::strobe_bit_lsb +:
                         io_unit_pkg::strobe_bit_w];
        now_b = pick_bit(dio_in, sel);
        old_b = pick_bit(dio_prev, sel);
        unique case (strobe_cfg[io_unit_pkg::strobe_edge_lsb +:
                                io_unit_pkg::strobe_edge_w])
            io_unit_pkg::edge_rise: strobe_hit = now_b && !old_b;
            io_unit_pkg::edge_fall: strobe_hit = !now_b && old_b;
            io_unit_pkg::edge_both: strobe_hit = now_b != old_b;
            io_unit_pkg::edge_off: strobe_hit = 1'b0;
        endcase
    end

    // Last port sample, the reference for edge detection
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dio_prev <= 32'h0000_0000;
        end else begin
            dio_prev <= dio_in;
        end
    end

    // Every strobe overwrites the capture, so reads see the newest
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dio_latched <= 32'h0000_0000;
        end else if (strobe_hit) begin
            dio_latched <= dio_in;
        end
    end

    // Write command stalls while the pacer is busy
    assign link.req = instr_valid && state == io_unit_pkg::st_idle &&
                      instr_op == io_unit_pkg::op_dio_write;
    assign link.data = instr_operand;
    assign instr_ready = state == io_unit_pkg::st_idle &&
                         (instr_op != io_unit_pkg::op_dio_write ||
                          link.ready);
    assign accept = instr_valid && instr_ready;

    dio_pacer dio_pacer_i (
        .hclk(hclk),
        .hresetn(hresetn),
        .link(link),
        .port_out(dio_out)
    );

    // Instruction sequencing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= io_unit_pkg::st_idle;
            wait_count <= 32'h0000_0000;
            pend_play <= 32'h0000_0000;
            sync_req <= 1'b0;
        end else begin
            unique case (state)
                io_unit_pkg::st_idle: begin
                    if (accept) begin
                        unique case (instr_op)
                            io_unit_pkg::op_wait: begin
                                if (instr_operand > 32'h1) begin
                                    wait_count <= instr_operand - 32'h2;
                                    state <= io_unit_pkg::st_wait;
                                end
                            end
                            io_unit_pkg::op_dio_trig_wait: begin
                                // An edge in the accept cycle ends it now
                                if (!strobe_hit) begin
                                    state <= io_unit_pkg::st_dio_wait;
                                end
                            end
                            io_unit_pkg::op_play_done_wait: begin
                                if (play_busy) begin
                                    state <= io_unit_pkg::st_play_wait;
                                end
                            end
                            io_unit_pkg::op_play: begin
                                // Index waits here for the running playback
                                pend_play <= instr_operand;
                                state <= io_unit_pkg::st_play_queue;
                            end
                            io_unit_pkg::op_sync: begin
                                sync_req <= 1'b1;
                                state <= io_unit_pkg::st_sync;
                            end
                            default: ;
                        endcase
                    end
                end
                io_unit_pkg::st_wait: begin
                    if (wait_count == 32'h0) begin
                        state <= io_unit_pkg::st_idle;
                    end else begin
                        wait_count <= wait_count - 32'h1;
                    end
                end
                io_unit_pkg::st_dio_wait: begin
                    if (strobe_hit) begin
                        state <= io_unit_pkg::st_idle;
                    end
                end
                io_unit_pkg::st_play_wait: begin
                    if (!play_busy) begin
                        state <= io_unit_pkg::st_idle;
                    end
                end
                io_unit_pkg::st_play_queue: begin
                    if (!play_busy) begin
                        state <= io_unit_pkg::st_idle;
                    end
                end
                io_unit_pkg::st_sync: begin
                    if (sync_ack) begin
                        sync_req <= 1'b0;
                        state <= io_unit_pkg::st_idle;
                    end
                end
                default: state <= io_unit_pkg::st_idle;
            endcase
        end
    end

    // Playback launch once the previous one has finished
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            play_start <= 1'b0;
            play_index <= 32'h0000_0000;
        end else begin
            play_start <= state == io_unit_pkg::st_play_queue &&
                          !play_busy;
            if (state == io_unit_pkg::st_play_queue && !play_busy) begin
                play_index <= pend_play;
            end
        end
    end

    // Trigger outputs and stream tag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trig_out <= 4'h0;
            stream_tag <= 32'h0000_0000;
        end else if (accept) begin
            if (instr_op == io_unit_pkg::op_trigger_out) begin
                trig_out <= instr_operand[3:0];
            end
            if (instr_op == io_unit_pkg::op_tag_set ||
                instr_op == io_unit_pkg::op_tag_alias) begin
                stream_tag <= instr_operand;
            end
        end
    end

    // Read results back to the sequencer variable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_valid <= 1'b0;
            result_data <= 32'h0000_0000;
        end else begin
            result_valid <= 1'b0;
            if (accept) begin
                unique case (instr_op)
                    io_unit_pkg::op_dio_read: begin
                        result_valid <= 1'b1;
                        result_data <= dio_in;
                    end
                    io_unit_pkg::op_dio_trig_read: begin
                        result_valid <= 1'b1;
                        result_data <= dio_latched;
                    end
                    io_unit_pkg::op_dig_trig_read: begin
                        result_valid <= 1'b1;
                        // index 1 or 2, others read 0
                        if (instr_operand == 32'h1) begin
                            result_data <= {31'h0, dig_trig_in[0]};
                        end else if (instr_operand == 32'h2) begin
                            result_data <= {31'h0, dig_trig_in[1]};
                        end else begin
                            result_data <= 32'h0000_0000;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // AHB-Lite slave: zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Address phase is kept so the write lands with its data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ahb_wr <= 1'b0;
            ahb_addr <= 8'h00;
        end else if (hready) begin
            ahb_wr <= hsel && htrans[1] && hwrite;
            ahb_addr <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strobe_cfg <= 10'h000;
        end else if (ahb_wr && ahb_addr == io_unit_pkg::addr_strobe_cfg) begin
            strobe_cfg <= hwdata[9:0];
        end
    end

    always_comb begin
        unique case (haddr[7:0])
            io_unit_pkg::addr_strobe_cfg: next_rdata = {22'h0, strobe_cfg};
            io_unit_pkg::addr_status: next_rdata = {26'h0, sync_req,
                play_busy, 1'b0, state};
            io_unit_pkg::addr_dio_out: next_rdata = dio_out;
            io_unit_pkg::addr_trig_out: next_rdata = {28'h0, trig_out};
            io_unit_pkg::addr_stream_tag: next_rdata = stream_tag;
            io_unit_pkg::addr_dio_latched: next_rdata = dio_latched;
            io_unit_pkg::addr_result: next_rdata = result_data;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata <= next_rdata;
        end
    end
endmodule
`default_nettype wire

// ===== seq_io_unit_sva.sv
// Concurrent checks on the I/O instruction unit ports
`timescale 1ns/100ps
`default_nettype none
module seq_io_unit_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic instr_valid,
    input wire logic [3:0] instr_op,
    input wire logic [31:0] instr_operand,
    input wire logic instr_ready,
    input wire logic result_valid,
    input wire logic [31:0] result_data,
    input wire logic [31:0] dio_in,
    input wire logic [31:0] dio_out,
    input wire logic [3:0] trig_out,
    input wire logic [1:0] dig_trig_in,
    input wire logic [31:0] stream_tag,
    input wire logic play_busy,
    input wire logic play_start,
    input wire logic sync_req
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    sequence s_take(logic [3:0] op);
        instr_valid && instr_ready && instr_op == op;
    endsequence
    sequence s_stall2;
        !instr_ready [*2] ##1 instr_ready;
    endsequence
    property p_write;
        s_take(io_unit_pkg::op_dio_write)
            |=> dio_out == $past(instr_operand);
    endproperty
    property p_hold;
        !(instr_valid && instr_op == io_unit_pkg::op_dio_write)
            |=> $stable(dio_out);
    endproperty
    property p_read;
        s_take(io_unit_pkg::op_dio_read)
            |=> result_valid && result_data == $past(dio_in);
    endproperty
    property p_trig;
        s_take(io_unit_pkg::op_trigger_out)
            |=> trig_out == $past(instr_operand[3:0]);
    endproperty
    property p_tag;
        instr_valid && instr_ready &&
            (instr_op == io_unit_pkg::op_tag_set ||
             instr_op == io_unit_pkg::op_tag_alias)
            |=> stream_tag == $past(instr_operand);
    endproperty
    property p_dig;
        s_take(io_unit_pkg::op_dig_trig_read) ##0 instr_operand == 32'h2
            |=> result_data == {31'h0, $past(dig_trig_in[1])};
    endproperty
    property p_wait;
        s_take(io_unit_pkg::op_wait) ##0 instr_operand == 32'h3
            |=> s_stall2;
    endproperty
    property p_zero;
        s_take(io_unit_pkg::op_wait) ##0 instr_operand == 32'h0
            |=> instr_ready;
    endproperty
    property p_pwait;
        s_take(io_unit_pkg::op_play_done_wait) ##0 play_busy
            |=> !instr_ready;
    endproperty
    property p_play;
        play_start |-> !$past(play_busy);
    endproperty
    property p_sync;
        s_take(io_unit_pkg::op_sync) |=> sync_req;
    endproperty
    a_write: assert property (p_write)
        else $error("port write value wrong");
    a_hold: assert property (p_hold)
        else $error("port output changed without write");
    a_read: assert property (p_read)
        else $error("port read result wrong");
    a_trig: assert property (p_trig)
        else $error("trigger lines wrong");
    a_tag: assert property (p_tag)
        else $error("stream tag wrong");
    a_dig: assert property (p_dig)
        else $error("digital trigger read wrong");
    a_wait: assert property (p_wait)
        else $error("wait length wrong");
    a_zero: assert property (p_zero)
        else $error("zero wait stalled");
    a_pwait: assert property (p_pwait)
        else $error("playback wait did not stall");
    a_play: assert property (p_play)
        else $error("playback started while busy");
    a_sync: assert property (p_sync)
        else $error("sync request missing");
endmodule
bind seq_io_unit seq_io_unit_chk seq_io_unit_chk_i (.hclk, .hresetn,
    .instr_valid, .instr_op, .instr_operand, .instr_ready, .result_valid,
    .result_data, .dio_in, .dio_out, .trig_out, .dig_trig_in, .stream_tag,
    .play_busy, .play_start, .sync_req);
`default_nettype wire

// ===== dio_partner.sv
// Model of the external equipment on the parallel port
`timescale 1ns/100ps
`default_nettype none
module dio_partner (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic arm,
    input wire logic [4:0] sbit,
    input wire logic [31:0] pat,
    output logic [31:0] dio_in
);
    logic [3:0] dly;
    // Strobe bit rises a fixed delay after arming and stays up
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            dly <= 4'h6;
        else if (!arm)
            dly <= 4'h6;
        else if (dly != 4'h0)
            dly <= dly - 4'h1;
    end
    assign dio_in = pat | (32'(arm && dly == 4'h0) << sbit);
endmodule
`default_nettype wire

// ===== test_sequencer_io_instruction_unit.sv
// Self-checking bench for the sequencer I/O instruction unit
`timescale 1ns/100ps
`default_nettype none
module test_sequencer_io_instruction_unit;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic instr_valid = 1'b0, arm = 1'b0, sync_ack = 1'b0;
    logic play_busy = 1'b0;
    logic [1:0] htrans = 2'h0, dig_trig_in = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [3:0] instr_op = 4'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, instr_operand = 32'h0;
    logic [31:0] pat = 32'h0, rd;
    logic [31:0] wv [4] = '{32'h0, 32'h1, 32'h3, 32'h5};
    wire logic hready, hresp, instr_ready, result_valid, play_start;
    wire logic sync_req;
    wire logic [3:0] trig_out;
    wire logic [31:0] hrdata, result_data, dio_in, dio_out, stream_tag;
    wire logic [31:0] play_index;
    int fails = 0, checks = 0, cyc = 0, n;
    always #20 hclk = ~hclk;
    seq_io_unit seq_io_unit_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready, .hreadyout(hready), .hresp,
        .hrdata, .instr_valid, .instr_op, .instr_operand, .instr_ready,
        .result_valid, .result_data, .dio_in, .dio_out, .trig_out,
        .dig_trig_in, .stream_tag, .play_busy, .play_start, .play_index,
        .sync_req, .sync_ack);
    dio_partner dio_partner_i (.hclk, .hresetn, .arm, .sbit(5'h3), .pat,
        .dio_in);
    task automatic end_sim;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            end_sim;
        end
    end
    task automatic chk(input logic [31:0] seen, exp, input string what);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask
    // Offer one instruction and return at the edge that takes it
    task automatic run(input logic [3:0] op, input logic [31:0] v);
        instr_valid <= 1'b1;
        instr_op <= op;
        instr_operand <= v;
        do @(posedge hclk); while (instr_ready !== 1'b1);
    endtask
    task automatic idle;
        instr_valid <= 1'b0;
        @(posedge hclk);
    endtask
    // Cycles from taking op until a following nop is taken
    task automatic gap(input logic [3:0] op, input logic [31:0] v);
        int t;
        run(op, v);
        t = cyc;
        run(io_unit_pkg::op_nop, 32'h0);
        n = cyc - t;
        idle;
    endtask
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk(dio_out, 32'h0, "dio reset");
        chk(trig_out, 32'h0, "trig reset");
        run(io_unit_pkg::op_dio_write, 32'hdead_beef);
        run(io_unit_pkg::op_dio_write, 32'h0000_0001);
        chk(dio_out, 32'hdead_beef, "dio first");
        idle;
        chk(dio_out, 32'h1, "dio write");
        ahb(1'b1, io_unit_pkg::addr_dio_out, 32'hffff_ffff, rd);
        ahb(1'b0, io_unit_pkg::addr_dio_out, 32'h0, rd);
        chk(rd, 32'h1, "dio reg");
        ahb(1'b0, 8'h40, 32'h0, rd);
        chk(rd, 32'h0, "unmapped");
        chk(hresp, 32'h0, "okay");
        for (int i = 0; i < 16; i += 5) begin
            run(io_unit_pkg::op_trigger_out, 32'(i) | 32'hfff0);
            idle;
            chk(trig_out, 32'(i), "trig");
        end
        chk(dio_out, 32'h1, "dio held");
        $display("test outputs done");
        foreach (wv[i]) begin
            gap(io_unit_pkg::op_wait, wv[i]);
            chk(32'(n), wv[i] == 0 ? 32'h1 : wv[i], "wait");
        end
        $display("test wait done");
        pat <= 32'h1234_5678;
        dig_trig_in <= 2'h2;
        run(io_unit_pkg::op_dio_read, 32'h0);
        idle;
        chk(result_valid, 32'h1, "read valid");
        chk(result_data, 32'h1234_5678, "read");
        for (int i = 0; i < 4; i++) begin
            run(io_unit_pkg::op_dig_trig_read, 32'(i));
            idle;
            chk(result_data, 32'(i == 2), "dig trig");
        end
        for (int i = 0; i < 2; i++) begin
            run(4'(io_unit_pkg::op_tag_set + i), 32'ha0 + i);
            idle;
            chk(stream_tag, 32'ha0 + i, "tag");
        end
        $display("test reads done");
        ahb(1'b1, io_unit_pkg::addr_strobe_cfg, 32'h0000_0103, rd);
        ahb(1'b0, io_unit_pkg::addr_strobe_cfg, 32'h0, rd);
        chk(rd, 32'h0000_0103, "strobe cfg");
        pat <= 32'h0000_5000;
        arm <= 1'b1;
        gap(io_unit_pkg::op_dio_trig_wait, 32'h0);
        chk(n >= 5 && n <= 10, 32'h1, "strobe wait");
        pat <= 32'h00ff_0000;
        run(io_unit_pkg::op_dio_trig_read, 32'h0);
        idle;
        chk(result_data, 32'h0000_5008, "latched");
        ahb(1'b0, io_unit_pkg::addr_dio_latched, 32'h0, rd);
        chk(rd, 32'h0000_5008, "latched reg");
        ahb(1'b1, io_unit_pkg::addr_strobe_cfg, 32'h0000_0203, rd);
        pat <= 32'h0000_0a00;
        arm <= 1'b0;
        gap(io_unit_pkg::op_dio_trig_wait, 32'h0);
        chk(32'(n), 32'h1, "fall wait");
        run(io_unit_pkg::op_dio_trig_read, 32'h0);
        idle;
        chk(result_data, 32'h0000_0a00, "fall latch");
        $display("test strobe done");
        play_busy <= 1'b1;
        fork
            gap(io_unit_pkg::op_play_done_wait, 32'h0);
            begin
                repeat (6) @(posedge hclk);
                play_busy <= 1'b0;
            end
        join
        chk(n >= 6 && n <= 9, 32'h1, "play wait");
        play_busy <= 1'b1;
        fork
            run(io_unit_pkg::op_play, 32'h0000_0042);
            begin
                repeat (5) begin
                    @(posedge hclk);
                    chk(play_start, 32'h0, "play held");
                end
                play_busy <= 1'b0;
            end
        join
        idle;
        n = 0;
        while (play_start !== 1'b1 && n < 20) begin
            @(posedge hclk);
            n++;
        end
        chk(play_start, 32'h1, "play start");
        chk(play_index, 32'h0000_0042, "play index");
        chk(32'(n), 32'h1, "play delay");
        $display("test playback done");
        run(io_unit_pkg::op_sync, 32'h0);
        idle;
        repeat (3) @(posedge hclk);
        chk(sync_req, 32'h1, "sync req");
        sync_ack <= 1'b1;
        run(io_unit_pkg::op_nop, 32'h0);
        sync_ack <= 1'b0;
        idle;
        chk(sync_req, 32'h0, "sync end");
        $display("test sync done");
        end_sim;
    end
endmodule
`default_nettype wire
